//--- pkg/sfs_pkg.sv
package sfs_pkg;
  localparam int DATA_W = 8;
  localparam int OPCODE_W = 16;
  localparam int BANK_W = 4;
  localparam int FILE_ADDR_W = 8;
  localparam int DOG_W = 8;
  localparam int POST_W = 16;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] DOG_CLEAR = 8'h00;
  localparam logic [15:0] HALT_OPCODE = 16'h0003;
  localparam logic [6:0] SET_ALL_PREFIX = 7'h34;
  localparam int SET_ALL_PREFIX_LSB = 9;
  localparam int SET_ALL_ACCESS_BIT = 8;
  localparam logic [3:0] ACCESS_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] DOG_TERMINAL = 8'hFF;
  // APB register offsets.
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h04;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFF_BANK = 8'h0C;
  localparam logic [7:0] OFF_DOG = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h14;
  localparam int ST_TIMEOUT_BIT = 0;
  localparam int ST_POWERDOWN_BIT = 1;
  localparam int ST_SLEEP_BIT = 2;
  localparam int IRQ_SET_ALL_BIT = 0;
  localparam int IRQ_SLEEP_BIT = 1;
  localparam int IRQ_WAKE_BIT = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [3:0] BANK_RESET = 4'h0;

  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} sfs_phase_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] data;
    logic we;
  } sfs_mem_wr_t;
endpackage

//--- rtl/sfs_watchdog.sv
`timescale 1ns/1ns
`default_nettype none
module sfs_watchdog #(
  parameter int POST_MAX = 16'h0003
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic clearReq,
  output logic [7:0] count,
  output logic timeoutPulse
);
  logic [15:0] postReg;
  logic [7:0] countReg;

  assign count = countReg;

  // Clear has priority over the tick so a halt never races a time-out.
  always_ff @(posedge ref_clk) begin
    if (reset || clearReq) begin
      postReg <= 16'h0000;
      countReg <= sfs_pkg::DOG_CLEAR; // [RULE6]
      timeoutPulse <= 1'b0;
    end else begin
      timeoutPulse <= 1'b0;
      if (enable) begin
        if (postReg >= POST_MAX[15:0]) begin
          postReg <= 16'h0000;
          if (countReg == sfs_pkg::DOG_TERMINAL) begin
            countReg <= sfs_pkg::DOG_CLEAR;
            timeoutPulse <= 1'b1;
          end else begin
            countReg <= countReg + 8'h01;
          end
        end else begin
          postReg <= postReg + 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/sfs_exec.sv
// Contract
// [RULE1] Set-all-ones is one word, one cycle: decode, read, process, write back.
// [RULE2] Set-all-ones writes FFh to the target and leaves arithmetic flags alone.
// [RULE3] Access bit 0 selects the access bank, 1 selects the bank select register.
// [RULE4] Halt clears the power-down flag.
// [RULE5] Halt sets the time-out flag.
// [RULE6] Halt clears the watchdog counter to 00h and its postscaler.
// [RULE7] Halt enters sleep with oscillator stopped in the fourth phase.
// [RULE8] A watchdog time-out wake clears the time-out flag.
// [RULE9] Halt opcode is 0003h exactly, with no operands.
`timescale 1ns/1ns
`default_nettype none
module sfs_exec #(
  parameter int WATCHDOG_POST = 3
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  input wire logic [7:0] memRdData,
  input wire logic watchdogEnable,
  output logic [11:0] memRdAddr,
  output sfs_pkg::sfs_mem_wr_t memWr,
  output logic [1:0] qPhase,
  output logic instrDone,
  output logic sleeping,
  output logic oscStop,
  output logic timeoutFlag,
  output logic powerdownFlag,
  output logic [7:0] watchdogCount,
  output logic irq,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  sfs_pkg::sfs_phase_t phaseReg;
  logic [15:0] instrReg;
  logic isSetAll;
  logic isHalt;
  logic [11:0] targetAddr;
  logic [7:0] readReg;
  logic [3:0] bankSelectReg;
  logic [2:0] irqStatReg;
  logic [2:0] irqMaskReg;
  logic [2:0] irqEvent;
  logic [2:0] irqClear;
  logic sleepReg;
  logic timeoutFlagReg;
  logic powerdownFlagReg;
  logic haltExec;
  logic setAllDone;
  logic dogClear;
  logic dogTimeout;
  logic apbWrite;
  logic apbRead;
  logic ctrlClearReq;

  assign isSetAll = (instrReg[15:9] == sfs_pkg::SET_ALL_PREFIX); // [RULE1]
  assign isHalt = (instrReg == sfs_pkg::HALT_OPCODE); // [RULE9]

  // Access bank splits into low RAM and the high special-function page.
  always_comb begin
    if (instrReg[sfs_pkg::SET_ALL_ACCESS_BIT]) begin
      targetAddr = {bankSelectReg, instrReg[7:0]}; // [RULE3]
    end else if (instrReg[7:0] < sfs_pkg::ACCESS_SPLIT) begin
      targetAddr = {sfs_pkg::ACCESS_BANK, instrReg[7:0]}; // [RULE3]
    end else begin
      targetAddr = {sfs_pkg::ACCESS_HIGH_BANK, instrReg[7:0]}; // [RULE3]
    end
  end

  assign memRdAddr = targetAddr;
  assign qPhase = phaseReg;
  assign sleeping = sleepReg;
  assign oscStop = sleepReg;
  assign timeoutFlag = timeoutFlagReg;
  assign powerdownFlag = powerdownFlagReg;

  // Phase counter stalls while asleep, modelling the stopped oscillator.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phaseReg <= sfs_pkg::Q1;
    end else if (!sleepReg) begin
      unique case (phaseReg)
        sfs_pkg::Q1: phaseReg <= sfs_pkg::Q2;
        sfs_pkg::Q2: phaseReg <= sfs_pkg::Q3;
        sfs_pkg::Q3: phaseReg <= sfs_pkg::Q4;
        sfs_pkg::Q4: phaseReg <= sfs_pkg::Q1;
      endcase
    end
  end

  // The instruction is latched in Q1 and decoded across the cycle.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      instrReg <= 16'h0000;
    end else if (!sleepReg && phaseReg == sfs_pkg::Q1) begin
      instrReg <= instrValid ? instrWord : 16'hFFFF;
    end
  end

  // The read in Q2 is kept for completeness; the result never depends on it.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      readReg <= 8'h00;
    end else if (phaseReg == sfs_pkg::Q2 && isSetAll) begin
      readReg <= memRdData; // [RULE1]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      memWr <= '0;
    end else if (!sleepReg && phaseReg == sfs_pkg::Q3 && isSetAll) begin
      memWr.addr <= targetAddr;
      memWr.data <= sfs_pkg::ALL_ONES; // [RULE2]
      memWr.we <= 1'b1; // [RULE1]
    end else begin
      memWr <= '0;
    end
  end

  assign setAllDone = !sleepReg && phaseReg == sfs_pkg::Q4 && isSetAll;
  assign haltExec = !sleepReg && phaseReg == sfs_pkg::Q4 && isHalt;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      instrDone <= 1'b0;
    end else begin
      instrDone <= !sleepReg && phaseReg == sfs_pkg::Q4;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sleepReg <= 1'b0;
    end else if (haltExec) begin
      sleepReg <= 1'b1; // [RULE7]
    end else if (dogTimeout) begin
      sleepReg <= 1'b0;
    end
  end

  // Status flags reset to the power-on state; time-out outside sleep is a reset elsewhere.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      timeoutFlagReg <= 1'b1;
      powerdownFlagReg <= 1'b1;
    end else if (haltExec) begin
      timeoutFlagReg <= 1'b1; // [RULE5]
      powerdownFlagReg <= 1'b0; // [RULE4]
    end else if (dogTimeout && sleepReg) begin
      timeoutFlagReg <= 1'b0; // [RULE8]
    end
  end

  assign dogClear = haltExec || ctrlClearReq; // [RULE6]

  sfs_watchdog #(
    .POST_MAX(WATCHDOG_POST)
  ) u_dog (
    .ref_clk(ref_clk),
    .reset(reset),
    .enable(watchdogEnable),
    .clearReq(dogClear),
    .count(watchdogCount),
    .timeoutPulse(dogTimeout)
  );

  assign apbWrite = psel && penable && pwrite;
  assign apbRead = psel && !pwrite;
  assign pready = 1'b1;
  assign ctrlClearReq = apbWrite && paddr == sfs_pkg::OFF_CTRL && pwdata[0];

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      unique case (paddr)
        sfs_pkg::OFF_STATUS, sfs_pkg::OFF_IRQ_STAT, sfs_pkg::OFF_IRQ_MASK,
        sfs_pkg::OFF_BANK, sfs_pkg::OFF_DOG, sfs_pkg::OFF_CTRL: pslverr = 1'b0;
        default: pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (apbRead && !penable) begin
      unique case (paddr)
        sfs_pkg::OFF_STATUS: prdata <= {29'h0, sleepReg, powerdownFlagReg, timeoutFlagReg};
        sfs_pkg::OFF_IRQ_STAT: prdata <= {29'h0, irqStatReg};
        sfs_pkg::OFF_IRQ_MASK: prdata <= {29'h0, irqMaskReg};
        sfs_pkg::OFF_BANK: prdata <= {28'h0, bankSelectReg};
        sfs_pkg::OFF_DOG: prdata <= {24'h0, watchdogCount};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bankSelectReg <= sfs_pkg::BANK_RESET;
    end else if (apbWrite && paddr == sfs_pkg::OFF_BANK) begin
      bankSelectReg <= pwdata[3:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irqMaskReg <= sfs_pkg::IRQ_MASK_RESET;
    end else if (apbWrite && paddr == sfs_pkg::OFF_IRQ_MASK) begin
      irqMaskReg <= pwdata[2:0];
    end
  end

  assign irqEvent = {dogTimeout && sleepReg, haltExec, setAllDone};
  assign irqClear = (apbWrite && paddr == sfs_pkg::OFF_IRQ_STAT) ? pwdata[2:0] : 3'h0;

  // A new event in the clearing cycle survives the write-one-to-clear.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irqStatReg <= 3'h0;
    end else begin
      irqStatReg <= (irqStatReg & ~irqClear) | irqEvent;
    end
  end

  assign irq = |(irqStatReg & irqMaskReg);
endmodule
`default_nettype wire

//--- dv/sfs_exec_properties.sv
`timescale 1ns/1ns
`default_nettype none
module sfs_exec_properties (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  input wire sfs_pkg::sfs_mem_wr_t memWr,
  input wire logic [1:0] qPhase,
  input wire logic sleeping,
  input wire logic oscStop,
  input wire logic timeoutFlag,
  input wire logic powerdownFlag,
  input wire logic [7:0] watchdogCount
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire logic take;
  wire logic setAllTake;
  wire logic haltTake;
  wire logic [7:0] fileAddr;
  assign take = qPhase == 2'd0 && !sleeping && instrValid;
  assign setAllTake = take && instrWord[15:9] == sfs_pkg::SET_ALL_PREFIX;
  assign haltTake = take && instrWord == sfs_pkg::HALT_OPCODE;
  assign fileAddr = instrWord[7:0];
  AST_SET_ALL_WRITE: assert property (setAllTake |-> ##3 memWr.we && memWr.data == 8'hFF)
    else $error("set-all-ones write missing in fourth phase");
  AST_WE_PHASE: assert property (memWr.we |-> qPhase == 2'd3 && $past(qPhase) == 2'd2)
    else $error("memory write outside fourth phase");
  AST_ACCESS_BANK: assert property (setAllTake && !instrWord[8] && fileAddr < 8'h60 |->
    ##3 memWr.addr == {4'h0, $past(fileAddr, 3)})
    else $error("access bank address wrong");
  AST_HALT_PD: assert property (haltTake |-> ##4 sleeping && !powerdownFlag)
    else $error("power-down flag not cleared by halt");
  AST_HALT_TO: assert property (haltTake |-> ##4 timeoutFlag)
    else $error("time-out flag not set by halt");
  AST_HALT_WDT: assert property (haltTake |-> ##4 watchdogCount == 8'h00)
    else $error("watchdog not cleared by halt");
  AST_SLEEP_Q4: assert property ($rose(sleeping) |-> oscStop && $past(qPhase) == 2'd3)
    else $error("sleep entry not in fourth phase");
  AST_SLEEP_CAUSE: assert property ($rose(sleeping) |-> $past(haltTake, 4))
    else $error("sleep entered without halt opcode");
  AST_WAKE_TO: assert property ($fell(sleeping) |-> !timeoutFlag && !oscStop)
    else $error("watchdog wake left time-out flag set");
endmodule
bind sfs_exec sfs_exec_properties i_sfs_exec_properties (.ref_clk(ref_clk), .reset(reset),
  .instrValid(instrValid), .instrWord(instrWord), .memWr(memWr), .qPhase(qPhase), .sleeping(sleeping),
  .oscStop(oscStop), .timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag), .watchdogCount(watchdogCount));
`default_nettype wire

//--- dv/sfs_exec_test.sv
`timescale 1ns/1ns
`default_nettype none
module sfs_exec_test;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] instrWord = 16'hFFFF;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, sleeping, oscStop, timeoutFlag, powerdownFlag, irq;
  logic [1:0] qPhase;
  logic [7:0] watchdogCount;
  logic [11:0] memRdAddr;
  logic instrDone;
  sfs_pkg::sfs_mem_wr_t memWr;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  logic [15:0] words [3] = '{16'h6920, 16'h6820, 16'h6880};
  logic [11:0] addrs [3] = '{12'h520, 12'h020, 12'hF80};
  sfs_exec #(.WATCHDOG_POST(0)) i_sfs_exec (.ref_clk(ref_clk), .reset(reset), .instrValid(1'b1),
    .instrWord(instrWord), .memRdData(8'h00), .watchdogEnable(1'b1), .memRdAddr(memRdAddr), .memWr(memWr),
    .qPhase(qPhase), .instrDone(instrDone), .sleeping(sleeping), .oscStop(oscStop), .timeoutFlag(timeoutFlag),
    .powerdownFlag(powerdownFlag), .watchdogCount(watchdogCount), .irq(irq), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic results();
    if (failures == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // A hung wait for wake-up or pready ends here.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      results();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Leaves the bench mid-cycle in the fourth phase of the instruction.
  task automatic exec(input logic [15:0] w);
    @(negedge ref_clk);
    while (qPhase !== 2'd3) @(negedge ref_clk);
    @(posedge ref_clk) instrWord <= w;
    @(posedge ref_clk) instrWord <= 16'hFFFF;
    repeat (3) @(negedge ref_clk);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    apb(1'b0, sfs_pkg::OFF_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0003);
    apb(1'b0, 8'h40, 32'h0000_0000);
    check({rd[30:0], err}, 32'h0000_0001);
    apb(1'b1, sfs_pkg::OFF_BANK, 32'h0000_0005);
    for (int i = 0; i < 3; i++) begin
      exec(words[i]);
      check({11'h000, memWr}, {11'h000, addrs[i], 8'hFF, 1'b1});
      check({20'h0_0000, memRdAddr}, {20'h0_0000, addrs[i]});
      @(negedge ref_clk);
      check(memWr.we, 1'b0);
      check(instrDone, 1'b1);
    end
    apb(1'b0, sfs_pkg::OFF_IRQ_STAT, 32'h0000_0000);
    check({rd[30:0], irq}, {31'h0000_0001, 1'b0});
    apb(1'b1, sfs_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    @(negedge ref_clk);
    check(irq, 1'b1);
    apb(1'b1, sfs_pkg::OFF_IRQ_STAT, 32'h0000_0001);
    @(negedge ref_clk);
    check(irq, 1'b0);
    exec(16'h0007);
    @(negedge ref_clk);
    check(sleeping, 1'b0);
    exec(sfs_pkg::HALT_OPCODE);
    @(negedge ref_clk);
    check({sleeping, oscStop, timeoutFlag, powerdownFlag, watchdogCount}, 12'hE00);
    while (sleeping !== 1'b0) @(negedge ref_clk);
    check({oscStop, timeoutFlag, powerdownFlag}, 3'b000);
    apb(1'b0, sfs_pkg::OFF_IRQ_STAT, 32'h0000_0000);
    check(rd, 32'h0000_0006);
    exec(sfs_pkg::HALT_OPCODE);
    @(negedge ref_clk);
    check({sleeping, timeoutFlag}, 2'b11);
    results();
  end
endmodule
`default_nettype wire
